// [core/filt_pkg.sv]
package filt_pkg;
	localparam int NUM_WIN = 8;
	localparam int WIN_IDX_W = 3;
	localparam int RULE_SLOTS = 16;
	localparam int SLOT_IDX_W = 4;
	localparam int OFF_W = 5;
	localparam int WORD_W = 16;
	localparam int LIST_W = 11;
	localparam int PORT_W = 3;
	localparam int VLAN_W = 12;
	localparam int VSLOT_W = 2;
	localparam int USE_W = 11;
	localparam int CAP_W = 6;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [CAP_W-1:0] CAP_LIMIT = 6'h20;
	localparam logic [LIST_W-1:0] LIST_MIN = 11'h4B0;
	localparam logic [LIST_W-1:0] LIST_MAX = 11'h513;
	localparam logic DEFAULT_PERMIT_RST = 1'b1;

	localparam logic [ADDR_W-1:0] REG_TMPL_SET = 12'h000;
	localparam logic [ADDR_W-1:0] REG_TMPL_DEL = 12'h004;
	localparam logic [ADDR_W-1:0] REG_TMPL_STAT = 12'h008;
	localparam logic [ADDR_W-1:0] REG_RULE_VM = 12'h00C;
	localparam logic [ADDR_W-1:0] REG_RULE_SLOT = 12'h010;
	localparam logic [ADDR_W-1:0] REG_RULE_CMD = 12'h014;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h018;
	localparam logic [ADDR_W-1:0] REG_PORT_BIND = 12'h01C;
	localparam logic [ADDR_W-1:0] REG_VLAN_BIND = 12'h020;
	localparam logic [ADDR_W-1:0] REG_STAT_SEL = 12'h024;
	localparam logic [ADDR_W-1:0] REG_STAT_CNT = 12'h028;
	localparam logic [ADDR_W-1:0] REG_DEFAULT = 12'h02C;

	localparam int F_TMPL_WIN_LSB = 0;
	localparam int F_TMPL_OFF_LSB = 8;
	localparam int F_TSTAT_USED_LSB = 8;
	localparam int F_VM_VALUE_LSB = 0;
	localparam int F_VM_MASK_LSB = 16;
	localparam int F_SLOT_LSB = 0;
	localparam int F_SLOT_WIN_LSB = 4;
	localparam int F_SLOT_EN = 8;
	localparam int F_CMD_LIST_LSB = 0;
	localparam int F_CMD_PERMIT = 16;
	localparam int F_CMD_DELETE = 17;
	localparam int F_BIND_PORT_LSB = 0;
	localparam int F_BIND_VLAN_LSB = 0;
	localparam int F_BIND_SLOT_LSB = 12;
	localparam int F_BIND_LIST_LSB = 16;
	localparam int F_BIND_STATS = 28;
	localparam int F_BIND_REMOVE = 29;
	localparam int F_STAT_BUSY = 0;
	localparam int F_STAT_ERR = 1;
	localparam int F_STAT_COUNT_LSB = 8;

	typedef struct packed {
		logic sof;
		logic last;
		logic ingress;
		logic [PORT_W-1:0] port;
		logic [VLAN_W-1:0] vlan;
		logic [WORD_W-1:0] data;
	} pkt_word_type;

	typedef struct packed {
		logic en;
		logic [WIN_IDX_W-1:0] win;
		logic [WORD_W-1:0] value;
		logic [WORD_W-1:0] mask;
	} win_match_type;

	typedef struct packed {
		logic valid;
		logic [LIST_W-1:0] list;
		logic permit;
		win_match_type [RULE_SLOTS-1:0] slots;
	} rule_type;

	typedef struct packed {
		logic done;
		logic applied;
		logic hit;
		logic permit;
	} verdict_type;
endpackage

// [core/rule_mem.sv]
module rule_mem
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 64,
	parameter int AW = 6
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge pclk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Read data comes out of a register, one cycle after the address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end
endmodule

// [core/offset_window_packet_filter.sv]
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module offset_window_packet_filter
#(
	parameter int NUM_PORTS = 8,
	parameter int NUM_VBIND = 4,
	parameter int DEPTH = 64,
	parameter int AW = 6
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [filt_pkg::ADDR_W-1:0] paddr,
	input wire logic [filt_pkg::DATA_W-1:0] pwdata,
	output logic [filt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire filt_pkg::pkt_word_type pkt_in,
	input wire logic pkt_valid,
	output logic pkt_ready,
	output filt_pkg::verdict_type verdict
);
	import filt_pkg::*;

	localparam int NB = NUM_PORTS + NUM_VBIND;
	localparam int SEL_W = $clog2(NB);

	typedef enum {S_IDLE, S_READ, S_TEST} state_type;

	state_type state, next_state;
	logic [AW-1:0] idx, next_idx;
	logic [AW:0] rule_count, next_rule_count, nidx;
	logic op_delete, next_op_delete, cmd_err, next_cmd_err, default_permit, next_default_permit;
	logic [LIST_W-1:0] cur_list, next_cur_list;
	logic [SEL_W-1:0] cur_bind, next_cur_bind, stat_sel, next_stat_sel, bind_idx;
	logic [NUM_WIN-1:0][OFF_W-1:0] tmpl_off, next_tmpl_off;
	logic [NUM_WIN-1:0] tmpl_cfg, next_tmpl_cfg, used_map;
	logic [NUM_WIN-1:0][USE_W-1:0] use_cnt, next_use_cnt;
	logic [DATA_W-1:0] vm_stage, next_vm_stage, next_prdata;
	win_match_type [RULE_SLOTS-1:0] stage, next_stage;
	logic [NB-1:0] bind_valid, next_bind_valid, bind_stats, next_bind_stats;
	logic [NB-1:0][LIST_W-1:0] bind_list, next_bind_list;
	logic [NB-1:0][VLAN_W-1:0] bind_vlan, next_bind_vlan;
	logic [NB-1:0][DATA_W-1:0] bind_cnt, next_bind_cnt;
	verdict_type next_verdict;
	logic busy, acc_wr, mapped, cmd_list_ok, bind_list_ok, tmpl_miss, bind_found, del_go, cls_start;
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	rule_type mem_wdata, rule_rdata;
	logic [WIN_IDX_W-1:0] wsel;
	logic [SEL_W-1:0] bsel;

	logic [CAP_W-1:0] word_idx, next_word_idx, cur_idx;
	logic [NUM_WIN-1:0][WORD_W-1:0] cap, next_cap;
	logic pend, next_pend, pend_ingress, next_pend_ingress;
	logic [PORT_W-1:0] pend_port, next_pend_port;
	logic [VLAN_W-1:0] pend_vlan, next_pend_vlan;

	function automatic logic rule_hits(input rule_type r, input logic [NUM_WIN-1:0][WORD_W-1:0] c);
		logic ok;
		ok = 1'b1;
		for (int s = 0; s < RULE_SLOTS; s++)
		begin
			if (r.slots[s].en && (((c[r.slots[s].win] ^ r.slots[s].value) & r.slots[s].mask) != '0))
				ok = 1'b0;
		end
		return ok;
	endfunction

	rule_mem #(.WIDTH($bits(rule_type)), .DEPTH(DEPTH), .AW(AW)) u_rules
	(
		.pclk(pclk),
		.presetn(presetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(idx),
		.rdata(rule_rdata)
	);

	assign busy = state != S_IDLE;
	assign acc_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign mapped = paddr inside {REG_TMPL_SET, REG_TMPL_DEL, REG_TMPL_STAT, REG_RULE_VM, REG_RULE_SLOT,
		REG_RULE_CMD, REG_STATUS, REG_PORT_BIND, REG_VLAN_BIND, REG_STAT_SEL, REG_STAT_CNT, REG_DEFAULT};
	assign pslverr = psel && penable && (!mapped || (pwrite && busy));
	assign cmd_list_ok = pwdata[F_CMD_LIST_LSB +: LIST_W] >= LIST_MIN && pwdata[F_CMD_LIST_LSB +: LIST_W] <= LIST_MAX;
	assign bind_list_ok = pwdata[F_BIND_LIST_LSB +: LIST_W] >= LIST_MIN && pwdata[F_BIND_LIST_LSB +: LIST_W] <= LIST_MAX;
	assign del_go = acc_wr && !busy && paddr == REG_RULE_CMD && pwdata[F_CMD_DELETE] && cmd_list_ok;
	assign cls_start = state == S_IDLE && !del_go && pend;
	assign pkt_ready = state == S_IDLE && !pend;
	assign wsel = pwdata[F_TMPL_WIN_LSB +: WIN_IDX_W];
	assign nidx = {1'b0, idx} + 1'b1;

	// Binding lookup: port bindings win over VLAN bindings, lowest entry first
	always_comb
	begin
		bind_found = 1'b0;
		bind_idx = '0;
		tmpl_miss = 1'b0;
		for (int b = NB - 1; b >= 0; b--)
		begin
			if (bind_valid[b] && ((b < NUM_PORTS) ? pend_port == PORT_W'(b) : pend_vlan == bind_vlan[b]))
			begin
				bind_found = 1'b1;
				bind_idx = SEL_W'(b);
			end
		end
		for (int w = 0; w < NUM_WIN; w++)
			used_map[w] = use_cnt[w] != '0;
		for (int s = 0; s < RULE_SLOTS; s++)
		begin
			if (stage[s].en && !tmpl_cfg[stage[s].win])
				tmpl_miss = 1'b1;
		end
	end

	always_comb
	begin
		next_state = state;
		next_idx = idx;
		next_rule_count = rule_count;
		next_op_delete = op_delete;
		next_cmd_err = cmd_err;
		next_default_permit = default_permit;
		next_cur_list = cur_list;
		next_cur_bind = cur_bind;
		next_stat_sel = stat_sel;
		next_tmpl_off = tmpl_off;
		next_tmpl_cfg = tmpl_cfg;
		next_use_cnt = use_cnt;
		next_vm_stage = vm_stage;
		next_stage = stage;
		next_bind_valid = bind_valid;
		next_bind_stats = bind_stats;
		next_bind_list = bind_list;
		next_bind_vlan = bind_vlan;
		next_bind_cnt = bind_cnt;
		next_verdict = verdict;
		next_verdict.done = 1'b0;
		next_prdata = prdata;
		mem_we = 1'b0;
		mem_waddr = rule_count[AW-1:0];
		mem_wdata = rule_rdata;
		bsel = '0;
		if (psel && !penable)
		begin
			case (paddr)
				REG_TMPL_STAT: next_prdata = DATA_W'({used_map, tmpl_cfg});
				REG_RULE_VM: next_prdata = vm_stage;
				REG_STATUS: next_prdata = DATA_W'({rule_count, 6'h00, cmd_err, busy});
				REG_STAT_SEL: next_prdata = DATA_W'(stat_sel);
				REG_STAT_CNT: next_prdata = (int'(stat_sel) < NB) ? bind_cnt[stat_sel] : '0;
				REG_DEFAULT: next_prdata = DATA_W'(default_permit);
				default: next_prdata = '0;
			endcase
		end
		if (acc_wr && !busy)
		begin
			case (paddr)
				REG_TMPL_SET:
				begin
					next_cmd_err = used_map[wsel];
					if (!used_map[wsel])
					begin
						next_tmpl_off[wsel] = pwdata[F_TMPL_OFF_LSB +: OFF_W];
						next_tmpl_cfg[wsel] = 1'b1;
					end
				end
				REG_TMPL_DEL:
				begin
					next_cmd_err = 1'b0;
					for (int w = 0; w < NUM_WIN; w++)
					begin
						if (pwdata[w] || pwdata[NUM_WIN-1:0] == '0)
						begin
							if (used_map[w])
								next_cmd_err = 1'b1;
							else
								next_tmpl_cfg[w] = 1'b0;
						end
					end
				end
				REG_RULE_VM: next_vm_stage = pwdata;
				REG_RULE_SLOT:
				begin
					bsel = SEL_W'(pwdata[F_SLOT_LSB +: SLOT_IDX_W]);
					next_stage[pwdata[F_SLOT_LSB +: SLOT_IDX_W]] = '{en: pwdata[F_SLOT_EN],
						win: pwdata[F_SLOT_WIN_LSB +: WIN_IDX_W], value: vm_stage[F_VM_VALUE_LSB +: WORD_W],
						mask: vm_stage[F_VM_MASK_LSB +: WORD_W]};
				end
				REG_RULE_CMD:
				begin
					next_cur_list = pwdata[F_CMD_LIST_LSB +: LIST_W];
					next_cmd_err = !cmd_list_ok;
					if (cmd_list_ok && pwdata[F_CMD_DELETE])
					begin
						next_op_delete = 1'b1;
						next_idx = '0;
						next_state = (rule_count == '0) ? S_IDLE : S_READ;
					end
					else if (cmd_list_ok)
					begin
						if (tmpl_miss || rule_count == (AW+1)'(DEPTH))
							next_cmd_err = 1'b1;
						else
						begin
							mem_we = 1'b1;
							mem_wdata = '{valid: 1'b1, list: pwdata[F_CMD_LIST_LSB +: LIST_W],
								permit: pwdata[F_CMD_PERMIT], slots: stage};
							next_rule_count = rule_count + 1'b1;
							for (int s = 0; s < RULE_SLOTS; s++)
							begin
								if (stage[s].en)
									next_use_cnt[stage[s].win] = next_use_cnt[stage[s].win] + 1'b1;
							end
						end
					end
				end
				REG_PORT_BIND, REG_VLAN_BIND:
				begin
					if (paddr == REG_PORT_BIND)
						bsel = SEL_W'(pwdata[F_BIND_PORT_LSB +: PORT_W]);
					else
						bsel = SEL_W'(NUM_PORTS + int'(pwdata[F_BIND_SLOT_LSB +: VSLOT_W]));
					next_cmd_err = !pwdata[F_BIND_REMOVE] && !bind_list_ok;
					if (pwdata[F_BIND_REMOVE] || bind_list_ok)
					begin
						next_bind_valid[bsel] = !pwdata[F_BIND_REMOVE];
						next_bind_stats[bsel] = !pwdata[F_BIND_REMOVE] && pwdata[F_BIND_STATS];
						next_bind_list[bsel] = pwdata[F_BIND_LIST_LSB +: LIST_W];
						next_bind_vlan[bsel] = pwdata[F_BIND_VLAN_LSB +: VLAN_W];
						next_bind_cnt[bsel] = '0;
					end
				end
				REG_STAT_SEL: next_stat_sel = pwdata[SEL_W-1:0];
				REG_DEFAULT: next_default_permit = pwdata[0];
				default: next_cmd_err = cmd_err;
			endcase
		end
		case (state)
			S_IDLE:
			begin
				if (cls_start)
				begin
					next_op_delete = 1'b0;
					next_idx = '0;
					next_cur_list = bind_list[bind_idx];
					next_cur_bind = bind_idx;
					if (!pend_ingress)
						next_verdict = '{done: 1'b1, applied: 1'b0, hit: 1'b0, permit: 1'b1};
					else if (!bind_found || rule_count == '0)
						next_verdict = '{done: 1'b1, applied: 1'b1, hit: 1'b0, permit: default_permit};
					else
						next_state = S_READ;
				end
			end
			S_READ: next_state = S_TEST;
			S_TEST:
			begin
				next_idx = nidx[AW-1:0];
				next_state = (nidx >= rule_count) ? S_IDLE : S_READ;
				if (rule_rdata.valid && rule_rdata.list == cur_list)
				begin
					if (op_delete)
					begin
						mem_we = 1'b1;
						mem_waddr = idx;
						mem_wdata.valid = 1'b0;
						for (int s = 0; s < RULE_SLOTS; s++)
						begin
							if (rule_rdata.slots[s].en)
								next_use_cnt[rule_rdata.slots[s].win] = next_use_cnt[rule_rdata.slots[s].win] - 1'b1;
						end
					end
					else if (rule_hits(rule_rdata, cap))
					begin
						next_state = S_IDLE;
						next_verdict = '{done: 1'b1, applied: 1'b1, hit: 1'b1, permit: rule_rdata.permit};
						if (bind_stats[cur_bind])
							next_bind_cnt[cur_bind] = bind_cnt[cur_bind] + 1'b1;
					end
				end
				if (!op_delete && nidx >= rule_count && next_state == S_IDLE && !next_verdict.done)
					next_verdict = '{done: 1'b1, applied: 1'b1, hit: 1'b0, permit: default_permit};
			end
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= S_IDLE;
			idx <= '0;
			rule_count <= '0;
			op_delete <= 1'b0;
			cmd_err <= 1'b0;
			default_permit <= DEFAULT_PERMIT_RST;
			cur_list <= '0;
			cur_bind <= '0;
			stat_sel <= '0;
			tmpl_off <= '0;
			tmpl_cfg <= '0;
			use_cnt <= '0;
			vm_stage <= '0;
			stage <= '0;
			bind_valid <= '0;
			bind_stats <= '0;
			bind_list <= '0;
			bind_vlan <= '0;
			bind_cnt <= '0;
			verdict <= '0;
			prdata <= '0;
		end
		else
		begin
			state <= next_state;
			idx <= next_idx;
			rule_count <= next_rule_count;
			op_delete <= next_op_delete;
			cmd_err <= next_cmd_err;
			default_permit <= next_default_permit;
			cur_list <= next_cur_list;
			cur_bind <= next_cur_bind;
			stat_sel <= next_stat_sel;
			tmpl_off <= next_tmpl_off;
			tmpl_cfg <= next_tmpl_cfg;
			use_cnt <= next_use_cnt;
			vm_stage <= next_vm_stage;
			stage <= next_stage;
			bind_valid <= next_bind_valid;
			bind_stats <= next_bind_stats;
			bind_list <= next_bind_list;
			bind_vlan <= next_bind_vlan;
			bind_cnt <= next_bind_cnt;
			verdict <= next_verdict;
			prdata <= next_prdata;
		end
	end

	// Window capture: word index counts two-byte words from the start of each packet (restarts on sof)
	always_comb
	begin
		cur_idx = pkt_in.sof ? '0 : word_idx;
		next_word_idx = word_idx;
		next_cap = cap;
		next_pend = pend && !cls_start;
		next_pend_ingress = pend_ingress;
		next_pend_port = pend_port;
		next_pend_vlan = pend_vlan;
		if (pkt_valid && pkt_ready)
		begin
			for (int w = 0; w < NUM_WIN; w++)
			begin
				if (tmpl_cfg[w] && {1'b0, tmpl_off[w]} == cur_idx)
					next_cap[w] = pkt_in.data;
			end
			if (cur_idx != CAP_LIMIT)
				next_word_idx = cur_idx + 1'b1;
			if (pkt_in.last)
			begin
				next_pend = 1'b1;
				next_pend_ingress = pkt_in.ingress;
				next_pend_port = pkt_in.port;
				next_pend_vlan = pkt_in.vlan;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_idx <= '0;
			cap <= '0;
			pend <= 1'b0;
			pend_ingress <= 1'b0;
			pend_port <= '0;
			pend_vlan <= '0;
		end
		else
		begin
			word_idx <= next_word_idx;
			cap <= next_cap;
			pend <= next_pend;
			pend_ingress <= next_pend_ingress;
			pend_port <= next_pend_port;
			pend_vlan <= next_pend_vlan;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_used_window_locked;
		acc_wr && !busy && paddr == REG_TMPL_SET && used_map[wsel] |=> cmd_err && tmpl_off == $past(tmpl_off);
	endproperty
	a_used_window_locked: assert property (p_used_window_locked)
		else $error("Template window changed while in use");

	property p_list_range;
		acc_wr && !busy && paddr == REG_RULE_CMD && !cmd_list_ok |=> cmd_err && $stable(rule_count) &&
			!(state == S_READ && op_delete);
	endproperty
	a_list_range: assert property (p_list_range)
		else $error("Out of range list id was accepted");

	property p_missing_window;
		acc_wr && !busy && paddr == REG_RULE_CMD && !pwdata[F_CMD_DELETE] && tmpl_miss |=> cmd_err && $stable(rule_count);
	endproperty
	a_missing_window: assert property (p_missing_window)
		else $error("Rule with unconfigured window was installed");

	property p_count_steps;
		rule_count != $past(rule_count) |-> rule_count == $past(rule_count) + 1'b1;
	endproperty
	a_count_steps: assert property (p_count_steps)
		else $error("Rule count moved by other than one append");

	property p_template_clear;
		acc_wr && !busy && paddr == REG_TMPL_DEL && pwdata[NUM_WIN-1:0] == '0 && used_map == '0 |=> tmpl_cfg == '0;
	endproperty
	a_template_clear: assert property (p_template_clear)
		else $error("Whole template delete left windows configured");

	property p_egress_passes;
		cls_start && !pend_ingress |=> verdict.done && !verdict.applied && verdict.permit;
	endproperty
	a_egress_passes: assert property (p_egress_passes)
		else $error("Non ingress packet was filtered");

	property p_unbound_default;
		cls_start && pend_ingress && !bind_found |=> verdict.done && !verdict.hit && verdict.permit == $past(default_permit);
	endproperty
	a_unbound_default: assert property (p_unbound_default)
		else $error("Unbound packet did not get default action");

	property p_walk_bounded;
		cls_start |-> ##[1:130] verdict.done;
	endproperty
	a_walk_bounded: assert property (p_walk_bounded)
		else $error("Classification did not finish");

	property p_hit_action;
		verdict.done && verdict.hit |-> verdict.permit == $past(rule_rdata.permit) && $past(state) == S_TEST;
	endproperty
	a_hit_action: assert property (p_hit_action)
		else $error("Verdict action differs from matching rule");
endmodule

// [sim/pkt_source.sv]
module pkt_source
	import filt_pkg::*;
(
	input wire logic pclk,
	input wire logic pkt_ready,
	output filt_pkg::pkt_word_type pkt_in,
	output logic pkt_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		pkt_in = '0;
		pkt_valid = 1'b0;
	end

	// Sends a four-word packet, top 16 bits (words[63:48]) first; each beat is held until taken
	task automatic send(input logic ing, input logic [PORT_W-1:0] port, input logic [VLAN_W-1:0] vlan,
		input logic [63:0] words);
		int i;
		for (i = 0; i < 4; i++)
		begin
			pkt_in.sof <= (i == 0);
			pkt_in.last <= (i == 3);
			pkt_in.ingress <= ing;
			pkt_in.port <= port;
			pkt_in.vlan <= vlan;
			pkt_in.data <= words[16*(3-i) +: 16];
			pkt_valid <= 1'b1;
			@(posedge pclk);
			while (pkt_ready !== 1'b1)
			begin
				@(posedge pclk);
			end
		end
		pkt_valid <= 1'b0;
		// Released data line no longer shows the last word
		pkt_in.data <= ~words[15:0];
	endtask
endmodule

// [sim/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import filt_pkg::*;

	localparam logic [63:0] PK_A = 64'h0003_1111_2222_AB12;
	localparam logic [63:0] PK_B = 64'h0003_1111_2222_AC12;
	localparam logic [63:0] PK_C = 64'h0004_1111_2222_AB12;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	pkt_word_type pkt_in;
	logic pkt_valid;
	logic pkt_ready;
	verdict_type verdict;
	logic [DATA_W-1:0] rd_v;
	logic err_v;
	int errors = 0;
	int cmp_count = 0;

	always #5 pclk = ~pclk;

	offset_window_packet_filter dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pkt_in(pkt_in),
		.pkt_valid(pkt_valid),
		.pkt_ready(pkt_ready),
		.verdict(verdict)
	);

	pkt_source src (
		.pclk(pclk),
		.pkt_ready(pkt_ready),
		.pkt_in(pkt_in),
		.pkt_valid(pkt_valid)
	);

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1)
			errors++;
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		xfer(1'b0, a, '0);
		chk(rd_v, exp);
	endtask

	// Polls status until the engine has finished the last command
	task automatic cmd(input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		wr(REG_RULE_CMD, d);
		do
		begin
			xfer(1'b0, REG_STATUS, '0);
			n++;
		end
		while (rd_v[F_STAT_BUSY] !== 1'b0 && n < 100);
		if (rd_v[F_STAT_BUSY] !== 1'b0)
			errors++;
	endtask

	task automatic pkt(input logic ing, input logic [PORT_W-1:0] port, input logic [VLAN_W-1:0] vlan,
		input logic [63:0] words, input logic [1:0] hit_permit);
		int n;
		n = 0;
		src.send(ing, port, vlan, words);
		while (verdict.done !== 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		chk({29'h0, verdict.done, verdict.hit, verdict.permit}, {29'h0, 1'b1, hit_permit});
	endtask

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
		begin
			$display("Finished cleanly");
		end
		else
		begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial
	begin
		#300us;
		errors++;
		end_sim();
	end

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({31'h0, pkt_ready}, 32'h1);
		chk({31'h0, pready}, 32'h1);
		rd_chk(REG_STATUS, 32'h0);
		rd_chk(REG_DEFAULT, 32'h1);
		rd_chk(REG_TMPL_STAT, 32'h0);
		rd_chk(12'h030, 32'h0);
		chk({31'h0, err_v}, 32'h1);
		wr(REG_TMPL_SET, 32'h0000_0000);
		wr(REG_TMPL_SET, 32'h0000_0301);
		rd_chk(REG_TMPL_STAT, 32'h0000_0003);
		wr(REG_RULE_VM, 32'hFFFF_0003);
		wr(REG_RULE_SLOT, 32'h0000_0100);
		wr(REG_RULE_VM, 32'hFF00_AB00);
		rd_chk(REG_RULE_VM, 32'hFF00_AB00);
		wr(REG_RULE_SLOT, 32'h0000_0111);
		wr(REG_RULE_SLOT, 32'h0000_0122);
		cmd(32'h0000_04B0);
		chk(rd_v, 32'h0000_0002);
		wr(REG_RULE_SLOT, 32'h0000_0022);
		cmd(32'h0000_0514);
		chk(rd_v, 32'h0000_0002);
		cmd(32'h0000_04B0);
		chk(rd_v, 32'h0000_0100);
		wr(REG_TMPL_SET, 32'h0000_0500);
		rd_chk(REG_STATUS, 32'h0000_0102);
		wr(REG_TMPL_DEL, 32'h0000_0004);
		rd_chk(REG_STATUS, 32'h0000_0100);
		wr(REG_TMPL_DEL, 32'h0000_0001);
		rd_chk(REG_STATUS, 32'h0000_0102);
		rd_chk(REG_TMPL_STAT, 32'h0000_0303);
		wr(REG_RULE_SLOT, 32'h0000_0000);
		wr(REG_RULE_SLOT, 32'h0000_0011);
		wr(REG_RULE_VM, 32'hFFFF_0003);
		wr(REG_RULE_SLOT, 32'h0000_010F);
		cmd(32'h0001_04B0);
		chk(rd_v, 32'h0000_0200);
		wr(REG_PORT_BIND, 32'h14B0_0001);
		pkt(1'b1, 3'h1, 12'h000, PK_A, 2'b10);
		pkt(1'b1, 3'h1, 12'h000, PK_B, 2'b11);
		pkt(1'b1, 3'h1, 12'h000, PK_C, 2'b01);
		pkt(1'b0, 3'h1, 12'h000, PK_A, 2'b01);
		chk({31'h0, verdict.applied}, 32'h0);
		pkt(1'b1, 3'h2, 12'h000, PK_A, 2'b01);
		wr(REG_VLAN_BIND, 32'h04B0_0005);
		pkt(1'b1, 3'h2, 12'h005, PK_A, 2'b10);
		wr(REG_STAT_SEL, 32'h0000_0001);
		rd_chk(REG_STAT_SEL, 32'h0000_0001);
		rd_chk(REG_STAT_CNT, 32'h0000_0002);
		wr(REG_PORT_BIND, 32'h2000_0001);
		pkt(1'b1, 3'h1, 12'h000, PK_B, 2'b01);
		wr(REG_RULE_CMD, 32'h0002_04B0);
		// The delete walk over two rules is still running: this write is refused
		wr(REG_DEFAULT, 32'h0000_0000);
		chk({31'h0, err_v}, 32'h1);
		rd_chk(REG_DEFAULT, 32'h0000_0001);
		rd_chk(REG_STATUS, 32'h0000_0200);
		pkt(1'b1, 3'h2, 12'h005, PK_A, 2'b01);
		wr(REG_TMPL_DEL, 32'h0000_0002);
		rd_chk(REG_TMPL_STAT, 32'h0000_0001);
		wr(REG_TMPL_DEL, 32'h0000_0000);
		rd_chk(REG_TMPL_STAT, 32'h0000_0000);
		wr(REG_DEFAULT, 32'h0000_0000);
		pkt(1'b1, 3'h3, 12'h000, PK_A, 2'b00);
		end_sim();
	end
endmodule
